/* nbc_regs.svh */
// Field offsets, codes and timing constants of the network boot command handler.
`ifndef NBC_REGS_SVH
`define NBC_REGS_SVH
`define NBC_OFS_ID       10'h002
`define NBC_OFS_CODE     10'h012
`define NBC_OFS_RCODE    10'h013
`define NBC_OFS_MLEN     10'h014
`define NBC_OFS_F22      10'h016
`define NBC_OFS_RSVD     10'h018
`define NBC_OFS_BUFS     10'h018
`define NBC_OFS_BLEN     10'h01a
`define NBC_OFS_STA      10'h01c
`define NBC_OFS_ADDR_END 10'h020
`define NBC_OFS_DATA     10'h020
`define NBC_OFS_SESS     10'h022
`define NBC_OFS_TMO      10'h02e
`define NBC_OFS_CFG      10'h030
`define NBC_OFS_ID_LO    10'h010
`define NBC_HDR_BYTES    10'h016
`define NBC_REQ_BYTES    10'h080
`define NBC_RX_MAX       10'h1fc
`define NBC_DATA_MAX     16'h01ce
`define NBC_NUM_BUFS     16'h0001
`define NBC_BUF_LEN      16'h01fc
`define NBC_PROTO_VER    16'h0001
`define NBC_CODE_WRITE   8'h00
`define NBC_CODE_READ    8'h01
`define NBC_CODE_DISC    8'h04
`define NBC_CODE_BIND    8'h05
`define NBC_RC_OK        8'h00
`define NBC_RC_INVALID   8'ha1
`define NBC_RC_NOMEM     8'ha3
`define NBC_MLEN_REQ     16'h006a
`define NBC_MLEN_MEM     16'h000a
`define NBC_TMO_KEEP     16'h00ff
`define NBC_TMO_DEF_MS   16'h0bb8
`define NBC_TMO_STEP_MS  16'h0014
`define NBC_TMO_DEF_UNIT 12'h096
`define NBC_CLK_NS       32'h0000000a
`define NBC_NS_PER_MS    32'h000f4240
`define NBC_STEP_CYCLES  (32'(`NBC_TMO_STEP_MS) * `NBC_NS_PER_MS / `NBC_CLK_NS)
`define NBC_BCAST        48'hffffffffffff
`endif

/* nbc_pkg.sv */
// Types shared by the network boot command handler.
package nbc_pkg;
	typedef enum logic [2:0] {
		NBC_DISC_TX,
		NBC_DISC_WAIT,
		NBC_BIND_TX,
		NBC_BIND_WAIT,
		NBC_SESS_WAIT,
		NBC_EXEC,
		NBC_REPLY_TX
	} nbc_state_t;
endpackage

/* nbc_wait_timer.sv */
// Receive-wait timer counting in 20 ms steps.
`timescale 1ns/100ps
`include "nbc_regs.svh"
module nbc_wait_timer #(
	parameter int unsigned TICK_CYCLES = `NBC_STEP_CYCLES
)(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        start,
	input  wire logic [11:0] units,
	output logic             expired
);
	logic [31:0] pre_r;
	logic [31:0] pre_nxt;
	logic [11:0] left_r;
	logic [11:0] left_nxt;
	logic        run_r;
	logic        run_nxt;
	logic        exp_r;
	logic        exp_nxt;

	always_comb
	begin
		pre_nxt = pre_r;
		left_nxt = left_r;
		run_nxt = run_r;
		exp_nxt = 1'b0;
		if (start)
		begin
			pre_nxt = '0;
			left_nxt = units;
			run_nxt = (units != 12'h000); // R10
		end
		else if (run_r)
		begin
			if (pre_r == TICK_CYCLES - 1)
			begin
				pre_nxt = '0;
				left_nxt = left_r - 12'h001;
				if (left_r == 12'h001)
				begin
					run_nxt = 1'b0;
					exp_nxt = 1'b1;
				end
			end
			else
				pre_nxt = pre_r + 32'h1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pre_r <= '0;
			left_r <= '0;
			run_r <= 1'b0;
			exp_r <= 1'b0;
		end
		else
		begin
			pre_r <= pre_nxt;
			left_r <= left_nxt;
			run_r <= run_nxt;
			exp_r <= exp_nxt;
		end
	end

	assign expired = exp_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	zero_never_a: assert property (start && units == 12'h000 |=> !run_r [*8]) else $error("zero timeout ran"); // R10
	expiry_cause_a: assert property ($rose(exp_r) |-> $past(run_r) && $past(left_r) == 12'h001) else $error("early expiry");
endmodule

/* nbc_boot_handler.sv */
// Network boot client: discovery, bind and session memory requests.
`timescale 1ns/100ps
`include "nbc_regs.svh"
// How it works
// R1 - Requests advertise one buffer; server keeps at most one request outstanding.
// R2 - Requests advertise 508-byte buffer; longer received frames are dropped.
// R3 - Requests carry our own station address in the station identifier.
// R4 - Server address comes from station identifier of discovery and bind replies.
// R5 - Bind reply gives session value; commands must match its 12 bytes.
// R6 - Timeout in milliseconds, rounded up to a 20 ms multiple.
// R7 - Default 3000 ms after reset and each discovery retry; resend on timeout.
// R8 - Discovery reply timeout goes into the bind request; bind reply may change it.
// R9 - Timeout value 0FFH keeps the current timeout.
// R10 - Timeout value 0 disables waiting limit.
// R11 - Discovery and bind requests carry the configuration snapshot.
// R12 - Server checks the board context code inside the snapshot.
// R13 - Replies echo all 16 message identifier bytes.
// R14 - Code 0 is write, 1 is read, echoed; reply code zero in requests.
// R15 - Write status 0, A3H on reserved overlap without copy, A1H invalid.
// R16 - Read status 0, A3H for missing memory without copy, A1H invalid.
// R17 - Write request length follows data; write reply length is 10.
// R18 - Read request length 10; reply length grows with data read.
// R19 - Length at 22, reserved at 24, address at 28, data at 32.
// R20 - Write reply length field gives bytes actually stored.
// R21 - Segment-and-offset address, echoed unchanged.
// R22 - Server limits write data to 462 bytes.
// R23 - Discovery code 4, bind code 5, echoed by server.
// R24 - Discovery and bind requests length 106, replies length 26.
// R25 - Commands with wrong session value are dropped silently.
module nbc_boot_handler #(
	parameter int unsigned TICK_CYCLES = `NBC_STEP_CYCLES,
	parameter logic [20:0] MEM_BYTES   = 21'h020000,
	parameter logic [20:0] RES_BASE    = 21'h000000,
	parameter logic [20:0] RES_END     = 21'h004000
)(
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [47:0]  station_addr,
	input  wire logic [639:0] cfg_snapshot,
	input  wire logic         rx_valid,
	input  wire logic [7:0]   rx_data,
	input  wire logic         rx_last,
	input  wire logic         tx_ready,
	output logic              tx_valid,
	output logic [7:0]        tx_data,
	output logic              tx_last,
	output logic [47:0]       tx_dest_addr,
	output logic              mem_en,
	output logic              mem_we,
	output logic [19:0]       mem_addr,
	output logic [7:0]        mem_wdata,
	input  wire logic [7:0]   mem_rdata,
	output logic              session_up,
	output logic [47:0]       server_addr
);
	// ----------------------------------------
	// Receive parsing
	// ----------------------------------------
	logic [9:0]   rxc_r, rxc_nxt;
	logic         bad_r, bad_nxt, done_r, done_nxt;
	logic [15:0]  sub_r, sub_nxt, mlen_r, mlen_nxt, f22_r, f22_nxt, tmo_r, tmo_nxt;
	logic [127:0] id_r, id_nxt;
	logic [7:0]   code_r, code_nxt, rcode_r, rcode_nxt;
	logic [47:0]  sta_r, sta_nxt;
	logic [31:0]  adr_r, adr_nxt;
	logic [95:0]  sess_r, sess_nxt;
	logic [7:0]   buf_mem [0:461];
	logic         buf_we;
	logic [8:0]   buf_wa;
	logic [7:0]   buf_wd;
	nbc_pkg::nbc_state_t st_r, st_nxt;
	logic [15:0]  ex_i_r, ex_i_nxt;
	logic [1:0]   ph_r, ph_nxt;
	logic         rx_ok;

	always_comb
	begin
		rxc_nxt = rxc_r;
		bad_nxt = bad_r;
		done_nxt = 1'b0;
		sub_nxt = sub_r;
		id_nxt = id_r;
		code_nxt = code_r;
		rcode_nxt = rcode_r;
		mlen_nxt = mlen_r;
		f22_nxt = f22_r;
		sta_nxt = sta_r;
		adr_nxt = adr_r;
		sess_nxt = sess_r;
		tmo_nxt = tmo_r;
		buf_we = 1'b0;
		buf_wa = '0;
		buf_wd = '0;
		if (rx_valid)
		begin
			rxc_nxt = rx_last ? 10'h000 : (rxc_r == 10'h3ff ? rxc_r : rxc_r + 10'h001);
			done_nxt = rx_last;
			bad_nxt = (rxc_r == 10'h000) ? 1'b0 : bad_r;
			if (rxc_r >= `NBC_RX_MAX)
				bad_nxt = 1'b1; // R2
			if (rxc_r < `NBC_OFS_ID)
				sub_nxt = {sub_r[7:0], rx_data};
			else if (rxc_r < `NBC_OFS_CODE)
				id_nxt = {id_r[119:0], rx_data};
			else if (rxc_r == `NBC_OFS_CODE)
				code_nxt = rx_data;
			else if (rxc_r == `NBC_OFS_RCODE)
				rcode_nxt = rx_data;
			else if (rxc_r < `NBC_OFS_F22)
				mlen_nxt = {mlen_r[7:0], rx_data};
			else if (rxc_r < `NBC_OFS_RSVD)
				f22_nxt = {f22_r[7:0], rx_data};
			if (rxc_r >= `NBC_OFS_STA && rxc_r < `NBC_OFS_SESS)
				sta_nxt = {sta_r[39:0], rx_data};
			if (rxc_r >= `NBC_OFS_STA && rxc_r < `NBC_OFS_ADDR_END)
				adr_nxt = {adr_r[23:0], rx_data}; // R19
			if (rxc_r >= `NBC_OFS_SESS && rxc_r < `NBC_OFS_TMO)
				sess_nxt = {sess_r[87:0], rx_data};
			if (rxc_r >= `NBC_OFS_TMO && rxc_r < `NBC_OFS_CFG)
				tmo_nxt = {tmo_r[7:0], rx_data};
			if (st_r == nbc_pkg::NBC_SESS_WAIT && rxc_r >= `NBC_OFS_DATA
				&& rxc_r < 10'(`NBC_OFS_DATA + `NBC_DATA_MAX))
			begin
				buf_we = 1'b1; // R19
				buf_wa = 9'(rxc_r - `NBC_OFS_DATA);
				buf_wd = rx_data;
			end
		end
		if (st_r == nbc_pkg::NBC_EXEC && code_r == `NBC_CODE_READ && ph_r == 2'h2)
		begin
			buf_we = 1'b1;
			buf_wa = 9'(ex_i_r);
			buf_wd = mem_rdata;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rxc_r <= '0;
			bad_r <= 1'b0;
			done_r <= 1'b0;
			sub_r <= '0;
			id_r <= '0;
			code_r <= '0;
			rcode_r <= '0;
			mlen_r <= '0;
			f22_r <= '0;
			sta_r <= '0;
			adr_r <= '0;
			sess_r <= '0;
			tmo_r <= '0;
		end
		else
		begin
			rxc_r <= rxc_nxt;
			bad_r <= bad_nxt;
			done_r <= done_nxt;
			sub_r <= sub_nxt;
			id_r <= id_nxt;
			code_r <= code_nxt;
			rcode_r <= rcode_nxt;
			mlen_r <= mlen_nxt;
			f22_r <= f22_nxt;
			sta_r <= sta_nxt;
			adr_r <= adr_nxt;
			sess_r <= sess_nxt;
			tmo_r <= tmo_nxt;
		end
	end

	always_ff @(posedge clk)
	begin
		if (buf_we)
			buf_mem[buf_wa] <= buf_wd;
	end

	assign rx_ok = done_r && !bad_r && sub_r == 16'h0000;

	// ----------------------------------------
	// Protocol sequencing
	// ----------------------------------------
	function automatic logic [11:0] ms_to_units(input logic [15:0] ms);
		logic [16:0] t;
		t = {1'b0, ms} + 17'(`NBC_TMO_STEP_MS - 16'h0001);
		return 12'(t / 17'(`NBC_TMO_STEP_MS));
	endfunction

	logic [11:0] units_r, units_nxt;
	logic [15:0] myid_r, myid_nxt, cnt_r, cnt_nxt, omlen_r, omlen_nxt;
	logic [47:0] srv_r, srv_nxt;
	logic [95:0] skey_r, skey_nxt;
	logic [7:0]  stat_r, stat_nxt, txd_r, txd_nxt;
	logic [9:0]  txc_r, txc_nxt;
	logic        men_r, men_nxt, mwe_r, mwe_nxt, sess_up_r, sess_up_nxt, tmr_start, expired;
	logic [19:0] madr_r, madr_nxt, phys;
	logic [7:0]  mwd_r, mwd_nxt;
	logic [20:0] blk_end;
	logic [17:0] tmo_ms;
	logic [9:0]  tx_total;
	logic        tx_req, sess_wait_tx;

	assign phys = 20'({adr_r[31:16], 4'h0}) + 20'(adr_r[15:0]); // R21
	assign blk_end = {1'b0, phys} + 21'(f22_r);
	assign tmo_ms = 18'(units_r) * 18'(`NBC_TMO_STEP_MS);
	assign tx_req = st_r == nbc_pkg::NBC_DISC_TX || st_r == nbc_pkg::NBC_BIND_TX;
	assign tx_total = tx_req ? `NBC_REQ_BYTES : 10'(`NBC_HDR_BYTES + 10'(omlen_r));
	assign tx_valid = tx_req || st_r == nbc_pkg::NBC_REPLY_TX;
	assign tx_last = tx_valid && txc_r == tx_total - 10'h001;

	nbc_wait_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_timer (
		.clk     (clk),
		.rst     (rst),
		.start   (tmr_start),
		.units   (units_nxt),
		.expired (expired)
	);

	always_comb
	begin
		st_nxt = st_r;
		units_nxt = units_r;
		myid_nxt = myid_r;
		srv_nxt = srv_r;
		skey_nxt = skey_r;
		stat_nxt = stat_r;
		cnt_nxt = cnt_r;
		omlen_nxt = omlen_r;
		ex_i_nxt = ex_i_r;
		ph_nxt = ph_r;
		men_nxt = 1'b0;
		mwe_nxt = 1'b0;
		madr_nxt = madr_r;
		mwd_nxt = mwd_r;
		sess_up_nxt = sess_up_r;
		txc_nxt = txc_r;
		unique case (st_r)
			nbc_pkg::NBC_DISC_TX, nbc_pkg::NBC_BIND_TX, nbc_pkg::NBC_REPLY_TX:
			begin
				if (tx_ready)
				begin
					txc_nxt = txc_r + 10'h001;
					if (tx_last)
					begin
						txc_nxt = '0;
						unique case (st_r)
							nbc_pkg::NBC_DISC_TX: st_nxt = nbc_pkg::NBC_DISC_WAIT;
							nbc_pkg::NBC_BIND_TX: st_nxt = nbc_pkg::NBC_BIND_WAIT;
							default:              st_nxt = nbc_pkg::NBC_SESS_WAIT;
						endcase
					end
				end
			end
			nbc_pkg::NBC_DISC_WAIT, nbc_pkg::NBC_BIND_WAIT:
			begin
				if (rx_ok && id_r == {112'h0, myid_r} && code_r == (st_r == nbc_pkg::NBC_DISC_WAIT ?
					`NBC_CODE_DISC : `NBC_CODE_BIND)) // R23
				begin
					srv_nxt = sta_r; // R4
					if (tmo_r != `NBC_TMO_KEEP)
						units_nxt = ms_to_units(tmo_r); // R6 R8 R9
					myid_nxt = myid_r + 16'h0001;
					if (st_r == nbc_pkg::NBC_DISC_WAIT)
						st_nxt = nbc_pkg::NBC_BIND_TX;
					else
					begin
						skey_nxt = sess_r; // R5
						sess_up_nxt = 1'b1;
						st_nxt = nbc_pkg::NBC_SESS_WAIT;
					end
				end
				else if (expired)
				begin
					units_nxt = `NBC_TMO_DEF_UNIT; // R7
					myid_nxt = myid_r + 16'h0001;
					st_nxt = nbc_pkg::NBC_DISC_TX;
				end
			end
			nbc_pkg::NBC_SESS_WAIT:
			begin
				if (rx_ok && id_r[127:32] == skey_r) // R5 R25
				begin
					ex_i_nxt = '0;
					ph_nxt = '0;
					cnt_nxt = f22_r;
					st_nxt = nbc_pkg::NBC_EXEC;
					stat_nxt = `NBC_RC_OK;
					if (rcode_r != `NBC_RC_OK || f22_r > `NBC_DATA_MAX) // R14 R22
						stat_nxt = `NBC_RC_INVALID;
					else if (code_r == `NBC_CODE_WRITE)
					begin
						if (mlen_r != `NBC_MLEN_MEM + f22_r) // R17
							stat_nxt = `NBC_RC_INVALID;
						else if (blk_end > RES_BASE && {1'b0, phys} < RES_END)
							stat_nxt = `NBC_RC_NOMEM; // R15
					end
					else if (code_r == `NBC_CODE_READ)
					begin
						if (mlen_r != `NBC_MLEN_MEM) // R18
							stat_nxt = `NBC_RC_INVALID;
						else if (blk_end > MEM_BYTES)
							stat_nxt = `NBC_RC_NOMEM; // R16
					end
					else
						stat_nxt = `NBC_RC_INVALID;
					if (stat_nxt != `NBC_RC_OK)
						cnt_nxt = '0;
				end
				else if (expired)
				begin
					units_nxt = `NBC_TMO_DEF_UNIT; // R7
					sess_up_nxt = 1'b0;
					myid_nxt = myid_r + 16'h0001;
					st_nxt = nbc_pkg::NBC_DISC_TX;
				end
			end
			nbc_pkg::NBC_EXEC:
			begin
				madr_nxt = 20'(phys + 20'(ex_i_r));
				if (ex_i_r >= cnt_r)
				begin
					omlen_nxt = `NBC_MLEN_MEM + (code_r == `NBC_CODE_READ ? cnt_r : 16'h0000); // R17 R18 R20
					st_nxt = nbc_pkg::NBC_REPLY_TX;
				end
				else if (code_r == `NBC_CODE_WRITE)
				begin
					men_nxt = 1'b1;
					mwe_nxt = 1'b1;
					mwd_nxt = buf_mem[9'(ex_i_r)];
					ex_i_nxt = ex_i_r + 16'h0001;
				end
				else
				begin
					men_nxt = ph_r == 2'h0;
					ph_nxt = ph_r == 2'h2 ? 2'h0 : ph_r + 2'h1;
					if (ph_r == 2'h2)
						ex_i_nxt = ex_i_r + 16'h0001;
				end
			end
		endcase
	end

	// Byte prefetch for the outgoing frame.
	always_comb
	begin
		txd_nxt = 8'h00;
		if (st_nxt == nbc_pkg::NBC_DISC_TX || st_nxt == nbc_pkg::NBC_BIND_TX)
		begin
			if (txc_nxt == `NBC_OFS_ID_LO)
				txd_nxt = myid_nxt[15:8];
			else if (txc_nxt == `NBC_OFS_ID_LO + 10'h001)
				txd_nxt = myid_nxt[7:0];
			else if (txc_nxt == `NBC_OFS_CODE)
				txd_nxt = st_nxt == nbc_pkg::NBC_DISC_TX ? `NBC_CODE_DISC : `NBC_CODE_BIND; // R23
			else if (txc_nxt == `NBC_OFS_MLEN + 10'h001)
				txd_nxt = 8'(`NBC_MLEN_REQ); // R24
			else if (txc_nxt == `NBC_OFS_F22 + 10'h001)
				txd_nxt = 8'(`NBC_PROTO_VER);
			else if (txc_nxt == `NBC_OFS_BUFS + 10'h001)
				txd_nxt = 8'(`NBC_NUM_BUFS); // R1
			else if (txc_nxt == `NBC_OFS_BLEN)
				txd_nxt = 8'(`NBC_BUF_LEN >> 8); // R2
			else if (txc_nxt == `NBC_OFS_BLEN + 10'h001)
				txd_nxt = 8'(`NBC_BUF_LEN); // R2
			else if (txc_nxt >= `NBC_OFS_STA && txc_nxt < `NBC_OFS_SESS)
				txd_nxt = 8'(station_addr >> {(`NBC_OFS_SESS - 10'h001 - txc_nxt), 3'b000}); // R3
			else if (txc_nxt == `NBC_OFS_TMO)
				txd_nxt = tmo_ms > 18'h0ffff ? 8'hff : tmo_ms[15:8]; // R8
			else if (txc_nxt == `NBC_OFS_TMO + 10'h001)
				txd_nxt = tmo_ms > 18'h0ffff ? 8'hff : tmo_ms[7:0];
			else if (txc_nxt >= `NBC_OFS_CFG)
				txd_nxt = 8'(cfg_snapshot >> {(`NBC_REQ_BYTES - 10'h001 - txc_nxt), 3'b000}); // R11
		end
		else if (st_nxt == nbc_pkg::NBC_REPLY_TX)
		begin
			if (txc_nxt >= `NBC_OFS_ID && txc_nxt < `NBC_OFS_CODE)
				txd_nxt = 8'(id_r >> {(`NBC_OFS_CODE - 10'h001 - txc_nxt), 3'b000}); // R13
			else if (txc_nxt == `NBC_OFS_CODE)
				txd_nxt = code_r; // R14
			else if (txc_nxt == `NBC_OFS_RCODE)
				txd_nxt = stat_nxt;
			else if (txc_nxt == `NBC_OFS_MLEN)
				txd_nxt = omlen_nxt[15:8];
			else if (txc_nxt == `NBC_OFS_MLEN + 10'h001)
				txd_nxt = omlen_nxt[7:0];
			else if (txc_nxt == `NBC_OFS_F22)
				txd_nxt = cnt_nxt[15:8]; // R20
			else if (txc_nxt == `NBC_OFS_F22 + 10'h001)
				txd_nxt = cnt_nxt[7:0];
			else if (txc_nxt >= `NBC_OFS_STA && txc_nxt < `NBC_OFS_ADDR_END)
				txd_nxt = 8'(adr_r >> {(`NBC_OFS_ADDR_END - 10'h001 - txc_nxt), 3'b000}); // R21
			else if (txc_nxt >= `NBC_OFS_DATA)
				txd_nxt = buf_mem[9'(txc_nxt - `NBC_OFS_DATA)]; // R18
		end
	end

	assign tmr_start = st_nxt != st_r && (st_nxt == nbc_pkg::NBC_DISC_WAIT ||
		st_nxt == nbc_pkg::NBC_BIND_WAIT || st_nxt == nbc_pkg::NBC_SESS_WAIT);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_r <= nbc_pkg::NBC_DISC_TX;
			units_r <= `NBC_TMO_DEF_UNIT; // R7
			myid_r <= '0;
			srv_r <= '0;
			skey_r <= '0;
			stat_r <= '0;
			cnt_r <= '0;
			omlen_r <= '0;
			ex_i_r <= '0;
			ph_r <= '0;
			men_r <= 1'b0;
			mwe_r <= 1'b0;
			madr_r <= '0;
			mwd_r <= '0;
			sess_up_r <= 1'b0;
			txc_r <= '0;
			txd_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
			units_r <= units_nxt;
			myid_r <= myid_nxt;
			srv_r <= srv_nxt;
			skey_r <= skey_nxt;
			stat_r <= stat_nxt;
			cnt_r <= cnt_nxt;
			omlen_r <= omlen_nxt;
			ex_i_r <= ex_i_nxt;
			ph_r <= ph_nxt;
			men_r <= men_nxt;
			mwe_r <= mwe_nxt;
			madr_r <= madr_nxt;
			mwd_r <= mwd_nxt;
			sess_up_r <= sess_up_nxt;
			txc_r <= txc_nxt;
			txd_r <= txd_nxt;
		end
	end

	assign tx_data = txd_r;
	assign tx_dest_addr = st_r == nbc_pkg::NBC_DISC_TX ? `NBC_BCAST : srv_r;
	assign mem_en = men_r;
	assign mem_we = mwe_r;
	assign mem_addr = madr_r;
	assign mem_wdata = mwd_r;
	assign session_up = sess_up_r;
	assign server_addr = srv_r;
	assign sess_wait_tx = st_r == nbc_pkg::NBC_REPLY_TX;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	buf_count_a: assert property (tx_req && txc_r == 10'h019 |-> tx_data == 8'h01) else $error("buffer count"); // R1
	buf_len_a: assert property (tx_req && (txc_r == 10'h01a || txc_r == 10'h01b) |-> tx_data == (txc_r == 10'h01a ? 8'h01 : 8'hfc)) else $error("buffer length"); // R2
	station_a: assert property (tx_req && txc_r == 10'h01c |-> tx_data == station_addr[47:40]) else $error("station address"); // R3
	discard_a: assert property (st_r == nbc_pkg::NBC_SESS_WAIT && rx_ok && id_r[127:32] != skey_r && !expired |=> st_r == nbc_pkg::NBC_SESS_WAIT) else $error("bad session accepted"); // R25
	write_guard_a: assert property (mem_en && mem_we |-> stat_r == 8'h00 && code_r == 8'h00) else $error("write without success"); // R15
	retry_def_a: assert property (st_r == nbc_pkg::NBC_DISC_WAIT && expired && !rx_ok |=> st_r == nbc_pkg::NBC_DISC_TX && units_r == 12'h096) else $error("retry timeout"); // R7
	wr_reply_len_a: assert property (sess_wait_tx && code_r == 8'h00 && txc_r == 10'h015 |-> tx_data == 8'h0a) else $error("write reply length"); // R17
	code_echo_a: assert property (sess_wait_tx && txc_r == 10'h012 |-> tx_data == code_r) else $error("code not echoed"); // R14
	req_len_a: assert property (tx_req && txc_r == 10'h015 |-> tx_data == 8'h6a) else $error("request length"); // R24
endmodule

/* nbc_server_model.sv */
// Boot server model: captures client frames and sends frames to the client.
`timescale 1ns/100ps
module nbc_server_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       slow,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_last,
	output logic            tx_ready,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            rx_last
);
	logic [7:0] frm [0:599];
	int         cnt      = 0;
	int         len      = 0;
	int         n_frames = 0;

	initial
	begin
		tx_ready = 1'b1;
		rx_valid = 1'b0;
		rx_data  = 8'h00;
		rx_last  = 1'b0;
	end

	// ------------------------------------------------------------
	// Frame capture with optional stalling.
	// ------------------------------------------------------------
	always @(posedge clk)
	begin
		tx_ready <= slow ? !tx_ready : 1'b1;
		if (rst)
			cnt <= 0;
		else if (tx_valid && tx_ready)
		begin
			frm[cnt] <= tx_data;
			cnt      <= tx_last ? 0 : cnt + 1;
			if (tx_last)
			begin
				len      <= cnt + 1;
				n_frames <= n_frames + 1;
			end
		end
	end

	// Sends one frame; callers keep frames short and one request outstanding.
	task automatic send(input logic [7:0] b [0:599], input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk);
			rx_valid <= 1'b1;
			rx_data  <= b[i];
			rx_last  <= (i == n - 1);
		end
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_last  <= 1'b0;
		rx_data  <= ~rx_data;
	endtask
endmodule

/* net_boot_command_handler_tb.sv */
// Testbench for the network boot command handler.
`timescale 1ns/100ps
module net_boot_command_handler_tb;
	logic          clk  = 1'b0;
	logic          rst  = 1'b1;
	logic          slow = 1'b0;
	logic [47:0]   sta  = 48'h021122334455;
	logic [639:0]  cfg  = {10{64'h0123456789abcdef}};
	logic          rx_valid, rx_data_last, tx_ready, tx_valid, tx_last, mem_en, mem_we, session_up;
	logic [7:0]    rx_data, tx_data, mem_wdata;
	logic [7:0]    mem_rdata = 8'h00;
	logic [19:0]   mem_addr;
	logic [47:0]   tx_dest_addr, server_addr;
	logic [7:0]    mem [0:131071];
	logic [7:0]    pkt [0:599];
	logic [95:0]   sess = 96'h5e5510a0b1c2d3e4f5061728;
	int            n_mismatch = 0;
	int            n_compared = 0;
	int            seen       = 0;

	always #5 clk = !clk;

	nbc_boot_handler #(.TICK_CYCLES(10)) dut_u (.clk(clk), .rst(rst), .station_addr(sta), .cfg_snapshot(cfg),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_data_last), .tx_ready(tx_ready),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_dest_addr(tx_dest_addr),
		.mem_en(mem_en), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .session_up(session_up), .server_addr(server_addr));

	nbc_server_model srv_u (.clk(clk), .rst(rst), .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_data_last));

	always @(posedge clk)
	begin
		if (mem_en && mem_we)
			mem[mem_addr[16:0]] <= mem_wdata;
		mem_rdata <= (mem_en && !mem_we) ? mem[mem_addr[16:0]] : ~mem_rdata;
	end

	// ------------------------------------------------------------
	// Helpers.
	// ------------------------------------------------------------
	task automatic stop_test;
		$display("compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [47:0] fld(input int ofs, input int n);
		logic [47:0] v;
		v = '0;
		for (int i = 0; i < n; i++)
			v = {v[39:0], srv_u.frm[ofs + i]};
		return v;
	endfunction

	task automatic put(input int ofs, input logic [95:0] v, input int n);
		for (int i = 0; i < n; i++)
			pkt[ofs + i] = v[8 * (n - 1 - i) +: 8];
	endtask

	task automatic frame(input int lim, input logic exp);
		int t;
		t = 0;
		while (srv_u.n_frames == seen && t < lim)
		begin
			@(posedge clk);
			t++;
		end
		chk(srv_u.n_frames != seen, exp);
		seen = srv_u.n_frames;
	endtask

	task automatic answer(input logic [47:0] a, input logic [95:0] s, input logic [15:0] tmo);
		for (int i = 0; i < 28; i++)
			pkt[i] = srv_u.frm[i];
		put(20, 16'h001a, 2);
		put(28, a, 6);
		put(34, s, 12);
		put(46, tmo, 2);
		chk(srv_u.frm[48], cfg[639 -: 8]);
		srv_u.send(pkt, 48);
	endtask

	task automatic cmd(input logic [7:0] c, input logic [95:0] s, input logic [31:0] a, input int ln, input int nd);
		put(0, 16'h0000, 2);
		put(2, s, 12);
		put(14, 32'hc0de0000 + ln, 4);
		put(18, {c, 8'h00}, 2);
		put(20, 10 + nd, 2);
		put(22, ln, 2);
		put(24, 32'h0, 4);
		put(28, a, 4);
		for (int i = 0; i < nd; i++)
			pkt[32 + i] = 8'h30 + i;
		srv_u.send(pkt, 32 + nd);
	endtask

	task automatic reply(input logic [7:0] st, input int ml, input int ln, input int tot);
		frame(2000, 1'b1);
		for (int i = 0; i < 19; i++)
			chk(srv_u.frm[i], pkt[i]);
		chk(fld(19, 1), st);
		chk(fld(20, 2), ml);
		chk(fld(22, 2), ln);
		chk(fld(28, 4), fld(0, 0) | {pkt[28], pkt[29], pkt[30], pkt[31]});
		chk(srv_u.len, tot);
	endtask

	// ------------------------------------------------------------
	// Test sequence.
	// ------------------------------------------------------------
	initial
	begin
		mem[17'h00100] = 8'h77;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		frame(2000, 1'b1);
		chk(srv_u.len, 128);
		chk(fld(18, 4), 32'h0400006a);
		chk(fld(24, 4), 32'h000101fc);
		chk(fld(28, 6), sta);
		chk(fld(46, 2), 3000);
		for (int i = 0; i < 80; i++)
			chk(srv_u.frm[48 + i], cfg[639 - 8 * i -: 8]);
		frame(2000, 1'b1);
		chk(fld(46, 2), 3000);
		answer(48'h0a0000000001, 96'h0, 16'h00ff);
		frame(500, 1'b1);
		chk(fld(18, 4), 32'h0500006a);
		chk(fld(46, 2), 3000);
		chk(fld(28, 6), sta);
		chk(tx_dest_addr, 48'h0a0000000001);
		frame(2000, 1'b1);
		chk(fld(18, 1), 8'h04);
		chk(fld(46, 2), 3000);
		answer(48'h0a0000000002, 96'h0, 16'd130);
		frame(500, 1'b1);
		chk(fld(46, 2), 140);
		chk(server_addr, 48'h0a0000000002);
		answer(48'h0a0000000003, sess, 16'h0000);
		repeat (3) @(posedge clk);
		chk(session_up, 1'b1);
		chk(server_addr, 48'h0a0000000003);
		frame(2000, 1'b0);
		slow <= 1'b1;
		cmd(8'h00, sess, 32'h10000010, 4, 4);
		reply(8'h00, 10, 4, 32);
		for (int i = 0; i < 4; i++)
			chk(mem[17'h10010 + i], 8'h30 + i);
		cmd(8'h01, sess, 32'h10000010, 4, 0);
		reply(8'h00, 14, 4, 36);
		for (int i = 0; i < 4; i++)
			chk(srv_u.frm[32 + i], 8'h30 + i);
		slow <= 1'b0;
		cmd(8'h00, sess, 32'h00000100, 2, 2);
		reply(8'ha3, 10, 0, 32);
		chk(mem[17'h00100], 8'h77);
		cmd(8'h01, sess, 32'h20000000, 2, 0);
		reply(8'ha3, 10, 0, 32);
		cmd(8'h01, sess, 32'h10000010, 463, 0);
		reply(8'ha1, 10, 0, 32);
		cmd(8'h00, sess, 32'h10000010, 5, 2);
		reply(8'ha1, 10, 0, 32);
		cmd(8'h02, sess, 32'h10000010, 0, 0);
		reply(8'ha1, 10, 0, 32);
		cmd(8'h00, sess ^ 96'h1, 32'h10000010, 1, 1);
		frame(500, 1'b0);
		chk(mem[17'h10010], 8'h30);
		stop_test;
	end

	initial
	begin
		repeat (30000) @(posedge clk);
		n_mismatch++;
		stop_test;
	end
endmodule
